// ---- design/arc_defs.vh ----
// Register map, field positions and reset values of the capture timer
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH

`define ARC_ADDR_CAPTURE_SELECT_STATUS 8'he1
`define ARC_ADDR_INPUT_B_IRQ_STATUS 8'he2
`define ARC_ADDR_TIMER_RUN_OVERFLOW_CONTROL 8'he8
`define ARC_ADDR_RELOAD_CAPTURE_HI 8'he9
`define ARC_ADDR_RELOAD_CAPTURE_LO 8'hea
`define ARC_ADDR_CAPTURE_HI 8'heb
`define ARC_ADDR_CAPTURE_LO 8'hec

// timer_run_overflow_control fields
`define ARC_PSC_HI 7
`define ARC_PSC_LO 6
`define ARC_RELOAD_EN 5
`define ARC_RUN 4
`define ARC_OVF_IEN 3
`define ARC_OVF_FLAG 2
`define ARC_OVF_MODE 1

// capture_select_status fields
`define ARC_A_ERR 6
`define ARC_B_ERR 5
`define ARC_A_IEN 4
`define ARC_A_FLAG 3
`define ARC_A_POL 2
`define ARC_RLD_HI 1
`define ARC_RLD_LO 0

// input_b_irq_status fields
`define ARC_B_POL 7
`define ARC_B_IEN 6
`define ARC_B_FLAG 5
`define ARC_CMP_IEN 4
`define ARC_CMP_FLAG 3
`define ARC_ZERO_IEN 2
`define ARC_ZERO_FLAG 1

// Prescaler codes and divide terminal counts
`define ARC_PSC_OFF 2'h0
`define ARC_PSC_DIV1 2'h1
`define ARC_PSC_DIV4 2'h2
`define ARC_PSC_DIV16 2'h3
`define ARC_DIV4_LAST 2'h3
`define ARC_DIV16_LAST 4'hf

// Reload source codes
`define ARC_RLD_RUN 2'h0
`define ARC_RLD_INPUT_A 2'h1
`define ARC_RLD_INPUT_B 2'h2
`define ARC_RLD_NONE 2'h3

`define ARC_REG8_RESET 8'h00
`define ARC_REG16_RESET 16'h0000
`define ARC_COUNT_ALL_ONES 16'hffff

`endif

// ---- design/arc_timer.v ----
// Capture, reload selection and interrupt logic of a 16-bit down-counting timer
`timescale 1ns/100ps
// How it works
// - Reload source 10 with run: input-B edge captures counter, then reloads it.
// - In input-B restart, capture only if B flag and B error clear; reload always.
// - In input-B restart, input-A edge only sets A flag or A error.
// - After reset first input-B edge captures zero, then loads and restarts counter.
// - Source 00: setting run reloads and starts; input-B edges capture counter.
// - Run set, reload clear: counter free-runs, restarting from all ones.
// - Free-running: A edge with A flags clear captures into reload register, sets flag.
// - Free-running: A edge while A flag set sets A error, no capture.
// - Free-running: B edge with B flags clear captures into capture register, sets flag.
// - Free-running: B edge while B flag set sets B error, no capture.
// - Interrupt is OR of five flag-and-enable terms.
// - Flags set regardless of enables; enabling a set flag raises interrupt at once.
// - Prescaler field bits 7:6: off, divide by 1, 4, 16.
// - Reset leaves prescaler off; software changes factor only while disabled.
// - Reload enable bit 5 permits reloads; clear makes reload register a capture target.
// - Run bit 4 clear holds counter at zero; set allows counting and input sync.
// - Overflow flag bit 2 sets on every overflow; software only clears it.
// - Overflow output: mode 0 set on overflow, cleared with flag; mode 1 toggles.
// - A error bit 6 sets on A event while A flag set and blocks A events.
// - B error bit 5 sets on B event while B flag set and blocks B flag and capture, not reload.
// - A polarity bit 2: zero falling edge, one rising edge.
// - B polarity: zero falling edge, one rising edge.
// - B flag marks first B event and capture since last clear; clear only.
`include "arc_defs.vh"

module arc_timer (
   input wire clk,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   output reg [7:0] reg_rdata,
   input wire capture_input_a,
   input wire capture_input_b,
   input wire compare_event,
   input wire zero_event,
   output wire timer_irq,
   output reg overflow_output,
   output reg [15:0] counter_value
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   reg [1:0] prescale_sel;
   reg reload_enable;
   reg run_or_clear;
   reg overflow_irq_enable;
   reg overflow_flag;
   reg overflow_output_mode;
   reg input_a_error;
   reg input_b_error;
   reg input_a_irq_enable;
   reg input_a_flag;
   reg input_a_polarity;
   reg [1:0] reload_source;
   reg input_b_polarity;
   reg input_b_irq_enable;
   reg input_b_flag;
   reg compare_irq_enable;
   reg compare_flag;
   reg zero_irq_enable;
   reg zero_flag;
   reg [15:0] reload_capture_register;
   reg [7:0] reload_hi_latch;
   reg [15:0] capture_register;
   reg [3:0] prescale_count;
   reg started;
   reg run_prev;
   reg [2:0] sync_a;
   reg [2:0] sync_b;

   wire wr_ctrl = reg_write && (reg_addr == `ARC_ADDR_TIMER_RUN_OVERFLOW_CONTROL);
   wire wr_sel = reg_write && (reg_addr == `ARC_ADDR_CAPTURE_SELECT_STATUS);
   wire wr_bst = reg_write && (reg_addr == `ARC_ADDR_INPUT_B_IRQ_STATUS);

   // Write-zero-to-clear with set priority
   function clear_flag;
      input flag;
      input hit;
      input wbit;
      input set;
      begin
         clear_flag = set | (flag & ~(hit & ~wbit));
      end
   endfunction

   // Active edge from the last two synchronised samples
   function active_edge;
      input [2:0] s;
      input pol;
      begin
         active_edge = pol ? (s[1] & ~s[2]) : (~s[1] & s[2]);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Prescaler and input synchronisers

   reg tick;
   always @* begin
      case (prescale_sel)
         `ARC_PSC_DIV1: tick = run_or_clear;
         `ARC_PSC_DIV4: tick = run_or_clear && (prescale_count[1:0] == `ARC_DIV4_LAST);
         `ARC_PSC_DIV16: tick = run_or_clear && (prescale_count == `ARC_DIV16_LAST);
         default: tick = 1'b0;
      endcase
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale_count <= 4'h0;
      end else if (prescale_sel == `ARC_PSC_OFF || !run_or_clear) begin
         prescale_count <= 4'h0;
      end else begin
         prescale_count <= prescale_count + 4'h1;
      end
   end

   // Stopped synchronisers track the pin, so starting makes no false edge
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sync_a <= 3'h0;
         sync_b <= 3'h0;
      end else if (run_or_clear) begin
         sync_a <= {sync_a[1:0], capture_input_a};
         sync_b <= {sync_b[1:0], capture_input_b};
      end else begin
         sync_a <= {3{capture_input_a}};
         sync_b <= {3{capture_input_b}};
      end
   end

   wire edge_a = run_or_clear && active_edge(sync_a, input_a_polarity);
   wire edge_b = run_or_clear && active_edge(sync_b, input_b_polarity);

   ////////////////////////////////////////////////////////////////////////////
   // Capture and reload decisions

   wire b_restart = reload_enable && (reload_source == `ARC_RLD_INPUT_B);
   wire a_free = edge_a && !input_a_flag && !input_a_error;
   wire b_free = edge_b && !input_b_flag && !input_b_error;
   wire set_a_flag = a_free;
   wire set_a_err = edge_a && input_a_flag;
   wire set_b_flag = b_free;
   wire set_b_err = edge_b && input_b_flag;
   wire capture_a = a_free && !reload_enable;
   wire capture_b = b_free;
   wire b_reload = edge_b && b_restart && run_or_clear;
   wire run_rise = run_or_clear && !run_prev;
   wire sw_reload = run_rise && reload_enable && (reload_source == `ARC_RLD_RUN);
   wire at_zero = (counter_value == `ARC_REG16_RESET);
   wire overflow_event = tick && started && at_zero;

   ////////////////////////////////////////////////////////////////////////////
   // Counter

   reg [15:0] next_counter_value;
   reg next_started;
   always @* begin
      next_counter_value = counter_value;
      next_started = started;
      if (!run_or_clear) begin
         next_counter_value = `ARC_REG16_RESET;
         next_started = 1'b0;
      end else if (b_reload || sw_reload) begin
         // Old value is captured on this same edge, before the load
         next_counter_value = reload_capture_register;
         next_started = 1'b1;
      end else if (run_rise && !b_restart) begin
         // Input-B restart stays at zero until its first edge
         next_started = 1'b1;
      end else if (tick && started) begin
         if (at_zero) begin
            if (reload_enable && reload_source != `ARC_RLD_NONE) begin
               next_counter_value = reload_capture_register;
            end else begin
               next_counter_value = `ARC_COUNT_ALL_ONES;
            end
         end else begin
            next_counter_value = counter_value - 16'h0001;
         end
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         counter_value <= `ARC_REG16_RESET;
         started <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         counter_value <= next_counter_value;
         started <= next_started;
         run_prev <= run_or_clear;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Capture register

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         capture_register <= `ARC_REG16_RESET;
      end else if (capture_b) begin
         capture_register <= counter_value;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register writes and flags

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prescale_sel <= `ARC_PSC_OFF;
         reload_enable <= 1'b0;
         run_or_clear <= 1'b0;
         overflow_irq_enable <= 1'b0;
         overflow_flag <= 1'b0;
         overflow_output_mode <= 1'b0;
         input_a_error <= 1'b0;
         input_b_error <= 1'b0;
         input_a_irq_enable <= 1'b0;
         input_a_flag <= 1'b0;
         input_a_polarity <= 1'b0;
         reload_source <= `ARC_RLD_RUN;
      end else begin
         if (wr_ctrl) begin
            prescale_sel <= reg_wdata[`ARC_PSC_HI:`ARC_PSC_LO];
            reload_enable <= reg_wdata[`ARC_RELOAD_EN];
            run_or_clear <= reg_wdata[`ARC_RUN];
            overflow_irq_enable <= reg_wdata[`ARC_OVF_IEN];
            overflow_output_mode <= reg_wdata[`ARC_OVF_MODE];
         end
         overflow_flag <= clear_flag(overflow_flag, wr_ctrl, reg_wdata[`ARC_OVF_FLAG],
            overflow_event);
         if (wr_sel) begin
            input_a_irq_enable <= reg_wdata[`ARC_A_IEN];
            input_a_polarity <= reg_wdata[`ARC_A_POL];
            reload_source <= reg_wdata[`ARC_RLD_HI:`ARC_RLD_LO];
         end
         input_a_error <= clear_flag(input_a_error, wr_sel, reg_wdata[`ARC_A_ERR],
            set_a_err);
         input_b_error <= clear_flag(input_b_error, wr_sel, reg_wdata[`ARC_B_ERR],
            set_b_err);
         input_a_flag <= clear_flag(input_a_flag, wr_sel, reg_wdata[`ARC_A_FLAG],
            set_a_flag);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Input-B, compare and zero status register

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         input_b_polarity <= 1'b0;
         input_b_irq_enable <= 1'b0;
         input_b_flag <= 1'b0;
         compare_irq_enable <= 1'b0;
         compare_flag <= 1'b0;
         zero_irq_enable <= 1'b0;
         zero_flag <= 1'b0;
      end else begin
         if (wr_bst) begin
            input_b_polarity <= reg_wdata[`ARC_B_POL];
            input_b_irq_enable <= reg_wdata[`ARC_B_IEN];
            compare_irq_enable <= reg_wdata[`ARC_CMP_IEN];
            zero_irq_enable <= reg_wdata[`ARC_ZERO_IEN];
         end
         input_b_flag <= clear_flag(input_b_flag, wr_bst, reg_wdata[`ARC_B_FLAG],
            set_b_flag);
         compare_flag <= clear_flag(compare_flag, wr_bst, reg_wdata[`ARC_CMP_FLAG],
            compare_event);
         zero_flag <= clear_flag(zero_flag, wr_bst, reg_wdata[`ARC_ZERO_FLAG],
            zero_event);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reload/capture register

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reload_capture_register <= `ARC_REG16_RESET;
         reload_hi_latch <= `ARC_REG8_RESET;
      end else begin
         // High byte waits in the latch until the low byte arrives
         if (reg_write && reg_addr == `ARC_ADDR_RELOAD_CAPTURE_HI) begin
            reload_hi_latch <= reg_wdata;
         end
         if (capture_a) begin
            reload_capture_register <= counter_value;
         end else if (reg_write && reload_enable &&
               reg_addr == `ARC_ADDR_RELOAD_CAPTURE_LO) begin
            reload_capture_register <= {reload_hi_latch, reg_wdata};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Overflow output pin

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overflow_output <= 1'b0;
      end else if (overflow_output_mode) begin
         if (overflow_event) begin
            overflow_output <= ~overflow_output;
         end
      end else begin
         overflow_output <= clear_flag(overflow_output, wr_ctrl,
            reg_wdata[`ARC_OVF_FLAG], overflow_event);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt and read-back

   wire irq_a = input_a_flag & input_a_irq_enable;
   wire irq_b = input_b_flag & input_b_irq_enable;
   wire irq_ovf = overflow_flag & overflow_irq_enable;
   wire irq_cmp = compare_flag & compare_irq_enable;
   wire irq_zero = zero_flag & zero_irq_enable;
   assign timer_irq = irq_a | irq_b | irq_ovf | irq_cmp | irq_zero;

   // Data stand for the one cycle after the strobe, zero otherwise
   reg [7:0] next_reg_rdata;
   always @* begin
      next_reg_rdata = `ARC_REG8_RESET;
      if (!reg_read) begin
         next_reg_rdata = `ARC_REG8_RESET;
      end else if (reg_addr == `ARC_ADDR_TIMER_RUN_OVERFLOW_CONTROL) begin
         next_reg_rdata = {prescale_sel, reload_enable, run_or_clear, overflow_irq_enable,
            overflow_flag, overflow_output_mode, 1'b0};
      end else if (reg_addr == `ARC_ADDR_CAPTURE_SELECT_STATUS) begin
         next_reg_rdata = {1'b0, input_a_error, input_b_error, input_a_irq_enable,
            input_a_flag, input_a_polarity, reload_source};
      end else if (reg_addr == `ARC_ADDR_INPUT_B_IRQ_STATUS) begin
         next_reg_rdata = {input_b_polarity, input_b_irq_enable, input_b_flag,
            compare_irq_enable, compare_flag, zero_irq_enable, zero_flag, 1'b0};
      end else if (reg_addr == `ARC_ADDR_RELOAD_CAPTURE_HI) begin
         next_reg_rdata = reload_capture_register[15:8];
      end else if (reg_addr == `ARC_ADDR_RELOAD_CAPTURE_LO) begin
         next_reg_rdata = reload_capture_register[7:0];
      end else if (reg_addr == `ARC_ADDR_CAPTURE_HI) begin
         next_reg_rdata = capture_register[15:8];
      end else if (reg_addr == `ARC_ADDR_CAPTURE_LO) begin
         next_reg_rdata = capture_register[7:0];
      end else begin
         next_reg_rdata = `ARC_REG8_RESET;
      end
   end

   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         reg_rdata <= `ARC_REG8_RESET;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

endmodule

// ---- verification/arc_pin_model.sv ----
// Behavioural model of the two external event pins
`timescale 1ns/100ps
module arc_pin_model (
   input wire clk,
   output reg pin_a,
   output reg pin_b
);
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
   end

   // Leave the active level, then enter it
   task ev(input sel_b, input pol);
      @(posedge clk);
      if (sel_b) pin_b <= ~pol;
      else pin_a <= ~pol;
      repeat (4) @(posedge clk);
      if (sel_b) pin_b <= pol;
      else pin_a <= pol;
      repeat (4) @(posedge clk);
      #1;
   endtask
endmodule

// ---- verification/arc_timer_assertions.sv ----
// Port-level assertions for the capture timer, bound to its top module
`timescale 1ns/100ps
module arc_timer_assertions (
   input wire clk,
   input wire resetn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_write,
   input wire reg_read,
   input wire [7:0] reg_rdata,
   input wire compare_event,
   input wire zero_event,
   input wire timer_irq,
   input wire overflow_output,
   input wire [15:0] counter_value
);
   reg [7:0] ctl;
   reg [7:0] sel;
   reg [7:0] bst;
   reg [2:0] steady;
   wire wr8 = reg_write && reg_addr == 8'he8;
   wire wr2 = reg_write && reg_addr == 8'he2;
   wire wrap = counter_value == 16'hffff;

   // Shadows of written control bits; cycles since the last control write
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ctl <= 8'h00;
         sel <= 8'h00;
         bst <= 8'h00;
         steady <= 3'h0;
      end else begin
         if (wr8) ctl <= reg_wdata;
         if (reg_write && reg_addr == 8'he1) sel <= reg_wdata;
         if (wr2) bst <= reg_wdata;
         if (wr8) steady <= 3'h0;
         else if (steady != 3'h4) steady <= steady + 3'h1;
      end
   end

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   a_rdata_quiet: assert property (!reg_read |=> reg_rdata == 8'h00)
      else $error("read data not zero outside read cycle");
   a_stop_zero: assert property (wr8 && !reg_wdata[4] |-> ##2 counter_value == 16'h0000)
      else $error("counter not cleared by run bit");
   a_psc_hold: assert property (ctl[7:5] == 3'h0 && steady == 3'h4 |-> $stable(counter_value))
      else $error("counter moved with prescaler off");
   a_div1_step: assert property (ctl[7:4] == 4'h5 && steady == 3'h4
      |-> counter_value == $past(counter_value) - 16'h0001)
      else $error("free count by one not decrementing");
   a_ovf_set: assert property (ctl[5:4] == 2'h1 && !ctl[1] && $past(counter_value) == 16'h0000
      && wrap |-> ##[0:1] overflow_output)
      else $error("overflow output not set on wrap");
   a_ovf_clear: assert property (wr8 && reg_wdata[2:1] == 2'h0 && counter_value > 16'h0002
      |-> ##2 !overflow_output)
      else $error("overflow output not cleared with flag");
   a_irq_none: assert property (!(sel[4] || bst[6] || bst[4] || bst[2] || ctl[3]) |-> !timer_irq)
      else $error("interrupt with all enables clear");
   a_irq_zero: assert property (zero_event && bst[2] && !wr2 |=> timer_irq)
      else $error("zero event did not raise interrupt");
   a_irq_cmp: assert property (compare_event && bst[4] && !wr2 |=> timer_irq)
      else $error("compare event did not raise interrupt");

   c_wrap: cover property ($past(counter_value) == 16'h0000 && wrap);
   c_zero_irq: cover property (zero_event && bst[2]);
   c_hold: cover property (ctl[7:4] == 4'h1 && steady == 3'h4);
endmodule

bind arc_timer arc_timer_assertions i_arc_timer_assertions (.clk(clk), .resetn(resetn),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
   .reg_rdata(reg_rdata), .compare_event(compare_event), .zero_event(zero_event),
   .timer_irq(timer_irq), .overflow_output(overflow_output), .counter_value(counter_value));

// ---- verification/tb.sv ----
// Self-checking testbench of the capture timer
`timescale 1ns/100ps
module tb;
   reg clk = 1'b0, resetn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
   reg compare_event = 1'b0, zero_event = 1'b0;
   reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   wire [7:0] reg_rdata;
   wire [15:0] counter_value;
   wire capture_input_a, capture_input_b, timer_irq, overflow_output;
   integer num_errors = 0, n_checks = 0, i, j, n;
   reg [15:0] v;

   arc_timer i_arc_timer (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .capture_input_a(capture_input_a),
      .capture_input_b(capture_input_b), .compare_event(compare_event),
      .zero_event(zero_event), .timer_irq(timer_irq),
      .overflow_output(overflow_output), .counter_value(counter_value));
   arc_pin_model i_arc_pin_model (.clk(clk), .pin_a(capture_input_a), .pin_b(capture_input_b));

   initial begin
      forever #25 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task check(input logic ok, input string msg);
      n_checks = n_checks + 1;
      if (ok !== 1'b1) begin
         num_errors = num_errors + 1;
         $display("CHECK FAILED at %0t ns: %0s", $time, msg);
      end
   endtask

   task tick(input integer k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task wr(input [7:0] a, input [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
      tick(1);
   endtask

   task rd(input [7:0] a, input [7:0] e, input string msg);
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      #1;
      check(reg_rdata === e, msg);
   endtask

   task pulse(input integer k);
      @(posedge clk);
      compare_event <= k == 0;
      zero_event <= k == 1;
      @(posedge clk);
      compare_event <= 1'b0;
      zero_event <= 1'b0;
      tick(1);
   endtask

   task test_done;
      $display("Errors %0d, checks %0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      for (i = 8'he1; i <= 8'hec; i = i + 1) rd(i[7:0], 8'h00, "reset value");
      wr(8'he8, 8'h20);
      wr(8'he9, 8'h12);
      wr(8'hea, 8'h34);
      rd(8'hea, 8'h34, "reload low");
      wr(8'he2, 8'hc0);
      wr(8'he1, 8'h02);
      wr(8'he8, 8'h30);
      tick(2);
      check(counter_value === 16'h0000, "held before first B");
      i_arc_pin_model.ev(1'b1, 1'b1);
      check(counter_value === 16'h1234, "reload on B");
      check(timer_irq === 1'b1, "B interrupt");
      rd(8'hec, 8'h00, "first capture");
      rd(8'he2, 8'he0, "B flag");
      wr(8'he9, 8'h56);
      wr(8'hea, 8'h78);
      i_arc_pin_model.ev(1'b1, 1'b1);
      check(counter_value === 16'h5678, "reload only");
      rd(8'heb, 8'h00, "no capture");
      rd(8'he1, 8'h22, "B error");
      i_arc_pin_model.ev(1'b0, 1'b0);
      rd(8'he1, 8'h2a, "A flag");
      i_arc_pin_model.ev(1'b0, 1'b0);
      rd(8'he1, 8'h6a, "A error");
      check(counter_value === 16'h5678, "A leaves counter");
      wr(8'he1, 8'h00);
      rd(8'he1, 8'h00, "flags cleared");
      wr(8'he2, 8'h80);
      wr(8'he8, 8'h20);
      tick(2);
      check(counter_value === 16'h0000, "run clear");
      wr(8'he8, 8'h30);
      tick(2);
      check(counter_value === 16'h5678, "run reload");
      i_arc_pin_model.ev(1'b1, 1'b1);
      rd(8'heb, 8'h56, "strobe capture");
      wr(8'he2, 8'h80);
      wr(8'he2, 8'ha0);
      rd(8'he2, 8'h80, "flag not settable");
      wr(8'he8, 8'h00);
      wr(8'he8, 8'h10);
      wr(8'he1, 8'h04);
      i_arc_pin_model.ev(1'b0, 1'b1);
      rd(8'he9, 8'h00, "A capture");
      i_arc_pin_model.ev(1'b1, 1'b1);
      rd(8'hec, 8'h00, "B capture");
      i_arc_pin_model.ev(1'b1, 1'b1);
      i_arc_pin_model.ev(1'b0, 1'b1);
      rd(8'he1, 8'h6c, "both errors");
      rd(8'he2, 8'ha0, "B flag kept");
      wr(8'he1, 8'h7c);
      check(timer_irq === 1'b1, "enable on set flag");
      wr(8'he1, 8'h00);
      for (i = 1; i < 4; i = i + 1) begin
         wr(8'he8, 8'h10);
         wr(8'he8, {i[1:0], 6'h10});
         for (j = 0; j < 2; j = j + 1) begin
            v = counter_value;
            n = 0;
            while (counter_value === v && n < 40) begin
               tick(1);
               n = n + 1;
            end
            check(n < 40, "counter step timeout");
         end
         check(n == (1 << (2 * i - 2)), "prescale period");
         if (n == 40) test_done;
      end
      wr(8'he8, 8'h00);
      check(overflow_output === 1'b0, "output follows flag");
      wr(8'he8, 8'h50);
      rd(8'he8, 8'h54, "overflow flag");
      check(overflow_output === 1'b1, "output set");
      wr(8'he8, 8'h5c);
      check(timer_irq === 1'b1, "overflow interrupt");
      wr(8'he8, 8'h58);
      check(timer_irq === 1'b0, "flag cleared");
      wr(8'he8, 8'h00);
      wr(8'he8, 8'h52);
      tick(2);
      check(overflow_output === 1'b1, "toggle");
      wr(8'he8, 8'h52);
      check(overflow_output === 1'b1, "toggle ignores flag");
      for (i = 0; i < 2; i = i + 1) begin
         pulse(i);
         check(timer_irq === 1'b0, "event masked");
         wr(8'he2, i ? 8'h86 : 8'h98);
         check(timer_irq === 1'b1, "enable raises");
         wr(8'he2, i ? 8'h84 : 8'h90);
         check(timer_irq === 1'b0, "event cleared");
         pulse(i);
         check(timer_irq === 1'b1, "event interrupt");
         wr(8'he2, 8'h80);
      end
      test_done;
   end
endmodule
